// [rtl/lfm_consts.vh]
// Purpose : Shared constants of the LED flash mode controller.
// Assumes : Included by the design file by its bare name.
// Notes   : Offsets are I2C register pointers, fields are bit positions.
`ifndef LFM_CONSTS_VH
`define LFM_CONSTS_VH

// ------------------------------------------------------------------
// Register pointers
// ------------------------------------------------------------------
`define LFM_REG_FLASH_TIMEOUT   8'h02
`define LFM_REG_LED_CURRENT     8'h03
`define LFM_REG_OUTPUT_MODE     8'h04
`define LFM_REG_FAULT_STATUS    8'h05
`define LFM_REG_TRIGGER_CFG     8'h07

// ------------------------------------------------------------------
// Field positions
// ------------------------------------------------------------------
`define LFM_TIMEOUT_MSB         3
`define LFM_FLASH_CUR_MSB       3
`define LFM_LOW_CUR_LSB         4
`define LFM_MODE_MSB            1
`define LFM_TRIG_SRC_BIT        2
`define LFM_OUT_EN_BIT          3
`define LFM_LEVEL_SENSE_BIT     4
`define LFM_POLARITY_BIT        0
`define LFM_FAULT_TIMEOUT_BIT   0

// ------------------------------------------------------------------
// Mode-select codes and reset values
// ------------------------------------------------------------------
`define LFM_MODE_STANDBY        2'h0
`define LFM_MODE_VOUT           2'h1
`define LFM_MODE_ASSIST         2'h2
`define LFM_MODE_FLASH          2'h3
`define LFM_RST_TIMEOUT         8'h00
`define LFM_RST_CURRENT         8'h00
`define LFM_RST_MODE            8'h00
`define LFM_RST_TRIGGER         8'h00

// ------------------------------------------------------------------
// Timing: one timeout step in microseconds, clock in MHz
// ------------------------------------------------------------------
`define LFM_STEP_US             100000
`define LFM_CLK_MHZ             250
`define LFM_STEP_CYC            (`LFM_STEP_US * `LFM_CLK_MHZ)

`endif

// [rtl/lfm_mode_ctrl.v]
// Purpose : Mode control of an LED flash driver behind an I2C slave.
// Assumes : scl and sda inputs are synchronous to clk_sys.
// Notes   : Analog current source and boost are outside; this block
//           only selects mode, level and on-time.
`timescale 1ns/100ps
`default_nettype none
`include "lfm_consts.vh"

module lfm_mode_ctrl #(
  parameter [6:0]  DEV_ADDR  = 7'h30,          // Arbitrary bus address
  parameter [31:0] STEP_CYC  = `LFM_STEP_CYC   // Cycles per timeout step
) (
  // Clock and reset
  input  wire       clk_sys,
  input  wire       reset_n,
  // Device enable pin
  input  wire       chip_en,
  // I2C slave pins, sda open drain
  input  wire       scl_i,
  input  wire       sda_i,
  output reg        sda_o,
  output reg        sda_oe_n,
  // Sensor strobe and torch request pins
  input  wire       strobe_pin,
  input  wire       torch_request_pin,
  // Drive controls toward the analog section
  output reg        led_drive_on,
  output reg  [3:0] led_level,
  output reg        flash_active,
  output reg        vout_enable
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam [2:0] ST_IDLE   = 3'h0;
  localparam [2:0] ST_ASSIST = 3'h1;
  localparam [2:0] ST_FLASH  = 3'h2;
  localparam [2:0] ST_TORCH  = 3'h3;
  localparam [2:0] ST_VOUT   = 3'h4;

  localparam [3:0] I_IDLE  = 4'h0;
  localparam [3:0] I_ADDR  = 4'h1;
  localparam [3:0] I_ACKA  = 4'h2;
  localparam [3:0] I_PTR   = 4'h3;
  localparam [3:0] I_ACKP  = 4'h4;
  localparam [3:0] I_WDAT  = 4'h5;
  localparam [3:0] I_ACKW  = 4'h6;
  localparam [3:0] I_RDAT  = 4'h7;
  localparam [3:0] I_RACK  = 4'h8;

  reg  [7:0]  flash_timeout_cfg_q;
  reg  [7:0]  led_current_cfg_q;
  reg  [7:0]  output_mode_ctrl_q;
  reg  [7:0]  indicator_trigger_cfg_q;
  reg         fault_timeout_q;

  reg  [3:0]  i2c_st_q;
  reg  [3:0]  bit_cnt_q;
  reg  [7:0]  shift_q;
  reg  [7:0]  ptr_q;
  reg         scl_q;
  reg         sda_q;
  reg         wr_stb_q;
  reg  [7:0]  wr_ptr_q;
  reg  [7:0]  wr_data_q;
  reg         rd_clr_q;
  reg  [7:0]  rd_data;

  reg  [2:0]  st_q;
  reg         strobe_prev_q;
  reg         level_mode_q;
  reg  [31:0] tick_q;
  reg  [4:0]  steps_q;

  wire        scl_rise   = scl_i & ~scl_q;
  wire        scl_fall   = ~scl_i & scl_q;
  wire        bus_start  = scl_i & scl_q & sda_q & ~sda_i;
  wire        bus_stop   = scl_i & scl_q & ~sda_q & sda_i;

  wire [1:0]  mode_select_field = output_mode_ctrl_q[`LFM_MODE_MSB:0];
  wire        out_en      = output_mode_ctrl_q[`LFM_OUT_EN_BIT];
  wire        trigger_source_select =
                output_mode_ctrl_q[`LFM_TRIG_SRC_BIT];
  wire        trigger_level_sense =
                output_mode_ctrl_q[`LFM_LEVEL_SENSE_BIT];
  wire        trigger_polarity =
                indicator_trigger_cfg_q[`LFM_POLARITY_BIT];
  wire [3:0]  flash_timeout = flash_timeout_cfg_q[`LFM_TIMEOUT_MSB:0];
  wire [3:0]  flash_current_level =
                led_current_cfg_q[`LFM_FLASH_CUR_MSB:0];
  wire [3:0]  low_current_level = led_current_cfg_q[7:`LFM_LOW_CUR_LSB];

  // Strobe seen as active-high whatever the sensor polarity
  wire        strobe_act  = strobe_pin ^ trigger_polarity;
  wire        strobe_edge = strobe_act & ~strobe_prev_q;
  wire        last_tick   = (tick_q == STEP_CYC - 32'h1);
  wire        timer_done  = last_tick & (steps_q == 5'h00);
  wire        hw_trig     = trigger_level_sense ? strobe_act
                                                : strobe_edge;

  // ----------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------
  // Unmapped pointers read as zero
  always @* begin
    if (ptr_q == `LFM_REG_FLASH_TIMEOUT) begin
      rd_data = flash_timeout_cfg_q;
    end else if (ptr_q == `LFM_REG_LED_CURRENT) begin
      rd_data = led_current_cfg_q;
    end else if (ptr_q == `LFM_REG_OUTPUT_MODE) begin
      rd_data = output_mode_ctrl_q;
    end else if (ptr_q == `LFM_REG_FAULT_STATUS) begin
      rd_data = {7'h00, fault_timeout_q};
    end else if (ptr_q == `LFM_REG_TRIGGER_CFG) begin
      rd_data = indicator_trigger_cfg_q;
    end else begin
      rd_data = 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // I2C slave
  // ----------------------------------------------------------------
  // Data changes on scl low, is sampled on scl rise; a write is only
  // handed on once its acknowledge clock has ended
  always @(posedge clk_sys) begin
    if (!reset_n || !chip_en) begin
      i2c_st_q  <= I_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q   <= 8'h00;
      ptr_q     <= 8'h00;
      scl_q     <= 1'b1;
      sda_q     <= 1'b1;
      sda_o     <= 1'b0;
      sda_oe_n  <= 1'b1;
      wr_stb_q  <= 1'b0;
      wr_ptr_q  <= 8'h00;
      wr_data_q <= 8'h00;
      rd_clr_q  <= 1'b0;
    end else begin
      scl_q    <= scl_i;
      sda_q    <= sda_i;
      wr_stb_q <= 1'b0;
      rd_clr_q <= 1'b0;
      if (bus_start) begin
        i2c_st_q  <= I_ADDR;
        bit_cnt_q <= 4'h0;
        sda_oe_n  <= 1'b1;
      end else if (bus_stop) begin
        i2c_st_q <= I_IDLE;
        sda_oe_n <= 1'b1;
      end else begin
        case (i2c_st_q)
          I_ADDR, I_PTR, I_WDAT: begin
            if (scl_rise) begin
              shift_q   <= {shift_q[6:0], sda_i};
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end else if (scl_fall && bit_cnt_q == 4'h8) begin
              bit_cnt_q <= 4'h0;
              if (i2c_st_q == I_ADDR && shift_q[7:1] != DEV_ADDR) begin
                i2c_st_q <= I_IDLE;       // Not ours, stay off the bus
              end else begin
                sda_oe_n <= 1'b0;         // Acknowledge
                i2c_st_q <= i2c_st_q + 4'h1;
              end
            end
          end
          I_ACKA: begin
            if (scl_fall) begin
              if (shift_q[0]) begin
                i2c_st_q <= I_RDAT;
                shift_q  <= rd_data;
                sda_oe_n <= rd_data[7];
                rd_clr_q <= 1'b1;
              end else begin
                i2c_st_q <= I_PTR;
                sda_oe_n <= 1'b1;
              end
            end
          end
          I_ACKP: begin
            if (scl_fall) begin
              ptr_q    <= shift_q;
              sda_oe_n <= 1'b1;
              i2c_st_q <= I_WDAT;
            end
          end
          I_ACKW: begin
            if (scl_fall) begin
              wr_stb_q  <= 1'b1;
              wr_ptr_q  <= ptr_q;
              wr_data_q <= shift_q;
              ptr_q     <= ptr_q + 8'h01;
              sda_oe_n  <= 1'b1;
              i2c_st_q  <= I_WDAT;
            end
          end
          I_RDAT: begin
            if (scl_fall) begin
              if (bit_cnt_q == 4'h7) begin
                bit_cnt_q <= 4'h0;
                sda_oe_n  <= 1'b1;        // Release for master ack
                i2c_st_q  <= I_RACK;
              end else begin
                bit_cnt_q <= bit_cnt_q + 4'h1;
                shift_q   <= {shift_q[6:0], 1'b0};
                sda_oe_n  <= shift_q[6];
              end
            end
          end
          I_RACK: begin
            if (scl_rise) begin
              if (sda_i) begin
                i2c_st_q <= I_IDLE;       // Master nack ends the read
              end else begin
                ptr_q    <= ptr_q + 8'h01;
              end
            end else if (scl_fall) begin
              i2c_st_q <= I_RDAT;         // Next byte after a master ack
              shift_q  <= rd_data;
              sda_oe_n <= rd_data[7];
              rd_clr_q <= 1'b1;
            end
          end
          default: begin
            i2c_st_q <= I_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers and mode sequencer
  // ----------------------------------------------------------------
  // Host writes land after hardware clears in this block, so a write
  // in the same cycle as an auto-clear keeps the host value
  always @(posedge clk_sys) begin
    if (!reset_n || !chip_en) begin
      flash_timeout_cfg_q     <= `LFM_RST_TIMEOUT;
      led_current_cfg_q       <= `LFM_RST_CURRENT;
      output_mode_ctrl_q      <= `LFM_RST_MODE;
      indicator_trigger_cfg_q <= `LFM_RST_TRIGGER;
      fault_timeout_q         <= 1'b0;
      st_q                    <= ST_IDLE;
      strobe_prev_q           <= 1'b0;
      level_mode_q            <= 1'b0;
      tick_q                  <= 32'h0;
      steps_q                 <= 5'h00;
      led_drive_on            <= 1'b0;
      led_level               <= 4'h0;
      flash_active            <= 1'b0;
      vout_enable             <= 1'b0;
    end else begin
      strobe_prev_q <= strobe_act;
      // Status read clears the fault; a new fault the same cycle wins
      if (rd_clr_q && ptr_q == `LFM_REG_FAULT_STATUS) begin
        fault_timeout_q <= 1'b0;
      end
      case (st_q)
        ST_IDLE: begin
          if (out_en && mode_select_field == `LFM_MODE_ASSIST) begin
            st_q <= ST_ASSIST;
          end else if (out_en && mode_select_field == `LFM_MODE_FLASH
                       && (!trigger_source_select || hw_trig)) begin
            st_q         <= ST_FLASH;
            level_mode_q <= trigger_source_select & trigger_level_sense;
            tick_q       <= 32'h0;
            steps_q      <= {1'b0, flash_timeout};
          end else if (out_en && mode_select_field == `LFM_MODE_STANDBY
                       && torch_request_pin) begin
            st_q <= ST_TORCH;
          end else if (out_en && mode_select_field == `LFM_MODE_VOUT) begin
            st_q <= ST_VOUT;
          end
        end
        ST_ASSIST: begin
          if (!out_en || mode_select_field != `LFM_MODE_ASSIST) begin
            st_q <= ST_IDLE;
          end
        end
        ST_VOUT: begin
          if (!out_en || mode_select_field != `LFM_MODE_VOUT) begin
            st_q <= ST_IDLE;
          end
        end
        ST_TORCH: begin
          if (strobe_act) begin
            st_q         <= ST_FLASH;
            level_mode_q <= trigger_level_sense;
            tick_q       <= 32'h0;
            steps_q      <= {1'b0, flash_timeout};
          end else if (!torch_request_pin) begin
            st_q <= ST_IDLE;
            output_mode_ctrl_q[`LFM_OUT_EN_BIT] <= 1'b0;
          end else if (!out_en) begin
            st_q <= ST_IDLE;
          end
        end
        ST_FLASH: begin
          tick_q <= last_tick ? 32'h0 : tick_q + 32'h1;
          if (last_tick && steps_q != 5'h00) begin
            steps_q <= steps_q - 5'h01;
          end
          if (!out_en) begin
            st_q <= ST_IDLE;
          end else if (level_mode_q && !strobe_act) begin
            st_q <= ST_IDLE;
            output_mode_ctrl_q[`LFM_MODE_MSB:0] <= `LFM_MODE_STANDBY;
            output_mode_ctrl_q[`LFM_OUT_EN_BIT] <= 1'b0;
          end else if (timer_done) begin
            st_q <= ST_IDLE;
            output_mode_ctrl_q[`LFM_MODE_MSB:0] <= `LFM_MODE_STANDBY;
            output_mode_ctrl_q[`LFM_OUT_EN_BIT] <= 1'b0;
            if (level_mode_q) begin
              fault_timeout_q <= 1'b1;
            end
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
      // Host register writes, applied after the acknowledge
      if (wr_stb_q) begin
        if (wr_ptr_q == `LFM_REG_FLASH_TIMEOUT) begin
          flash_timeout_cfg_q <= wr_data_q;
        end else if (wr_ptr_q == `LFM_REG_LED_CURRENT) begin
          led_current_cfg_q <= wr_data_q;
        end else if (wr_ptr_q == `LFM_REG_OUTPUT_MODE) begin
          output_mode_ctrl_q <= wr_data_q;
        end else if (wr_ptr_q == `LFM_REG_TRIGGER_CFG) begin
          indicator_trigger_cfg_q <= wr_data_q;
        end
      end
      // Drive outputs follow the state one cycle later
      led_drive_on <= (st_q == ST_ASSIST) | (st_q == ST_TORCH)
                    | (st_q == ST_FLASH);
      led_level    <= (st_q == ST_FLASH) ? flash_current_level
                                         : low_current_level;
      flash_active <= (st_q == ST_FLASH);
      vout_enable  <= (st_q == ST_VOUT);
    end
  end

endmodule // lfm_mode_ctrl
`default_nettype wire

// [verification/lfm_host_model.sv]
// Purpose: Bus host model for the controller's register port
// Assumes: sda_in is the resolved line, pulled up when idle
// Notes: Lines change only at falling clock edges; data bits change as scl rises
`timescale 1ns/100ps
`default_nettype none
module lfm_host_model #(
  parameter int         HP   = 4,     // Clocks per bus clock phase
  parameter logic [6:0] ADDR = 7'h30  // Arbitrary device address
) (
  // Clock and resolved data line
  input  wire logic clk_sys,
  input  wire logic sda_in,
  // Driven lines, one means released
  output var logic  scl,
  output var logic  sda
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // --------
  // Bus phases
  // --------
  task automatic ph(input logic c);
    scl = c;
    repeat (HP) @(negedge clk_sys);
  endtask
  // Nine bits; the ninth is our acknowledge, or one to hear the device
  task automatic xbyte(input logic [7:0] tx, input logic mack,
                       output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda = tx[i];
      ph(1'b1);
      rx[i] = sda_in;
      ph(1'b0);
    end
    sda = mack;
    ph(1'b1);
    ack = !sda_in;
    ph(1'b0);
  endtask
  // Start and stop hold the clock high while data moves
  task automatic start();
    sda = 1'b1;
    ph(1'b1);
    sda = 1'b0;
    ph(1'b1);
    ph(1'b0);
  endtask
  task automatic stop();
    sda = 1'b0;
    ph(1'b0);
    ph(1'b1);
    sda = 1'b1;
    ph(1'b1);
  endtask
  // Pointer write then data byte, or pointer then one read byte
  task automatic xfer(input logic rd, input logic [7:0] ptr,
                      input logic [7:0] wv, output logic [7:0] rv,
                      output logic ok);
    logic [7:0] rx;
    logic       a0;
    logic       a1;
    logic       a2;
    logic       nk;
    start();
    xbyte({ADDR, 1'b0}, 1'b1, rx, a0);
    xbyte(ptr, 1'b1, rx, a1);
    rv = wv;
    if (rd) begin
      stop();
      start();
      xbyte({ADDR, 1'b1}, 1'b1, rx, a2);
      xbyte(8'hFF, 1'b1, rv, nk);
    end else begin
      xbyte(wv, 1'b1, rx, a2);
    end
    stop();
    ok = a0 & a1 & a2;
  endtask
endmodule // lfm_host_model
`default_nettype wire

// [verification/lfm_mode_ctrl_monitor.sv]
// Purpose: Port checker for the LED flash mode controller
// Assumes: STEP_CYC matches the bound instance
// Notes: Mode bits are hidden, so checks tie pins to pins
`timescale 1ns/100ps
`default_nettype none
module lfm_mode_ctrl_monitor #(
  parameter [31:0] STEP_CYC = 32'h8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Watched pins
  input wire logic chip_en,
  input wire logic scl_i,
  input wire logic sda_oe_n,
  input wire logic led_drive_on,
  input wire logic flash_active,
  input wire logic vout_enable
);
  // --------
  // Helpers
  // --------
  // Flash length; saturates so a stuck flash is still caught
  logic [31:0] fl_cnt_q;
  always_ff @(posedge clk_sys) begin
    if (!reset_n || !flash_active) fl_cnt_q <= 32'h0;
    else if (fl_cnt_q != 32'hFFFFFFFF) fl_cnt_q <= fl_cnt_q + 32'h1;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // --------
  // Properties
  // --------
  property p_flash_drive;
    flash_active |-> led_drive_on;
  endproperty
  a_flash_drive: assert property (p_flash_drive)
    else $error("flash without drive");
  property p_vout_only;
    vout_enable |-> !led_drive_on && !flash_active;
  endproperty
  a_vout_only: assert property (p_vout_only)
    else $error("voltage mode with led drive");
  property p_chip_off;
    !chip_en |=> !led_drive_on && !vout_enable && sda_oe_n;
  endproperty
  a_chip_off: assert property (p_chip_off)
    else $error("outputs active while disabled");
  property p_flash_max;
    fl_cnt_q <= 16 * STEP_CYC + 1;
  endproperty
  a_flash_max: assert property (p_flash_max)
    else $error("flash longer than largest timeout");
  property p_flash_end;
    $fell(flash_active) |-> !led_drive_on;
  endproperty
  a_flash_end: assert property (p_flash_end)
    else $error("drive left on after flash");
  // Data line may only move while the bus clock is low
  property p_sda_steady;
    scl_i && $past(scl_i) |-> $stable(sda_oe_n);
  endproperty
  a_sda_steady: assert property (p_sda_steady)
    else $error("data moved in clock high");
  property p_ack_low;
    $fell(sda_oe_n) |-> !scl_i;
  endproperty
  a_ack_low: assert property (p_ack_low)
    else $error("data pulled during clock high");
  property p_ack_hold;
    $fell(sda_oe_n) |=> !sda_oe_n [*3];
  endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("acknowledge too short");
endmodule // lfm_mode_ctrl_monitor
bind lfm_mode_ctrl lfm_mode_ctrl_monitor #(.STEP_CYC(STEP_CYC)) u_mon (
  .clk_sys(clk_sys), .reset_n(reset_n), .chip_en(chip_en), .scl_i(scl_i),
  .sda_oe_n(sda_oe_n), .led_drive_on(led_drive_on),
  .flash_active(flash_active), .vout_enable(vout_enable));
`default_nettype wire

// [verification/tb_top.sv]
// Purpose: Self-checking bench of the LED flash mode controller
// Assumes: Timeout step shortened to STEP clocks
// Notes: Expected values come from the small model below
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam int STEP = 8;
  // --------
  // Signals and model state
  // --------
  logic       clk_sys = 1'b0;
  logic       reset_n = 1'b0;
  logic       chip_en = 1'b0;
  logic       strobe_pin = 1'b0;
  logic       torch_request_pin = 1'b0;
  logic       scl, sda_h, sda_o, sda_oe_n;
  logic       led_drive_on, flash_active, vout_enable;
  logic [3:0] led_level;
  logic [7:0] cur = 8'h00;  // Model of the current register, reset value
  int         tmo;
  int         num_errors = 0;
  int         samples_checked = 0;
  integer     seed = 64;
  // Open-drain data line with pull-up
  wire logic  sda_bus = sda_h & (sda_oe_n | sda_o);
  always #2 clk_sys = ~clk_sys;
  lfm_host_model u_host (.clk_sys(clk_sys), .sda_in(sda_bus), .scl(scl),
    .sda(sda_h));
  lfm_mode_ctrl #(.STEP_CYC(32'(STEP))) u_dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .chip_en(chip_en),
    .scl_i(scl), .sda_i(sda_bus), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
    .strobe_pin(strobe_pin), .torch_request_pin(torch_request_pin),
    .led_drive_on(led_drive_on), .led_level(led_level),
    .flash_active(flash_active), .vout_enable(vout_enable));
  // --------
  // Model and checks
  // --------
  function automatic logic [6:0] exp_out(int md, int en, int fl, int tor);
    logic dr;
    dr = (md == 2 && en == 1) || fl == 1 || tor == 1;
    return {dr, fl == 1, md == 1 && en == 1, fl == 1 ? cur[3:0] : cur[7:4]};
  endfunction
  // Tolerance only for lengths of level-sensed flashes
  task automatic chk(string nm, int tol, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (tol == 0 ? g !== e : (g + tol < e || g > e + tol)) begin
      num_errors++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic outs(int md, int en, int fl, int tor);
    chk("outputs", 0, 32'(exp_out(md, en, fl, tor)),
        32'({led_drive_on, flash_active, vout_enable, led_level}));
  endtask
  task automatic wr(logic [7:0] p, logic [7:0] v);
    logic [7:0] r;
    logic       ok;
    u_host.xfer(1'b0, p, v, r, ok);
    chk("write ack", 0, 32'h1, 32'(ok));
  endtask
  task automatic rd_chk(logic [7:0] p, logic [7:0] e);
    logic [7:0] r;
    logic       ok;
    u_host.xfer(1'b1, p, 8'h00, r, ok);
    chk("read data", 0, 32'(e), 32'(r));
  endtask
  // Counts flash cycles; a missing flash gives zero
  task automatic meas(output int n);
    int w;
    n = 0;
    w = 0;
    while (flash_active !== 1'b1 && w < 600) begin
      @(negedge clk_sys);
      w++;
    end
    if (flash_active === 1'b1) outs(3, 1, 1, 0);
    while (flash_active === 1'b1 && n < 1000) begin
      @(negedge clk_sys);
      n++;
    end
  endtask
  task automatic pulse(int len, logic act);
    strobe_pin = act;
    repeat (len) @(negedge clk_sys);
    strobe_pin = !act;
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // --------
  // Main sequence
  // --------
  initial begin
    int         n;
    static logic [7:0] mtab [8] = '{8'h03, 8'h02, 8'h0A, 8'h08, 8'h0A, 8'h02,
                                    8'h09, 8'h01};
    repeat (4) @(negedge clk_sys);
    outs(0, 0, 0, 0);
    chk("released", 0, 32'h1, 32'(sda_oe_n));
    reset_n = 1'b1;
    repeat (2) @(negedge clk_sys);
    chip_en = 1'b1;
    cur = 8'($random(seed));
    tmo = 2 + ($unsigned($random(seed)) % 14);
    wr(8'h03, cur);
    wr(8'h02, 8'(tmo));
    rd_chk(8'h03, cur);
    rd_chk(8'h02, 8'(tmo));
    wr(8'h06, 8'hA5);
    rd_chk(8'h06, 8'h00);
    foreach (mtab[i]) begin
      wr(8'h04, mtab[i]);
      outs(mtab[i][1:0], mtab[i][3], 0, 0);
    end
    fork
      wr(8'h04, 8'h0B);
      meas(n);
    join
    chk("soft flash", 0, (tmo + 1) * STEP, n);
    outs(0, 0, 0, 0);
    rd_chk(8'h04, 8'h00);
    // Edge timing under both strobe polarities
    for (int p = 0; p < 2; p++) begin
      strobe_pin = p[0];
      wr(8'h07, 8'(p));
      wr(8'h04, 8'h0F);
      repeat (20) @(negedge clk_sys);
      outs(3, 1, 0, 0);
      fork
        meas(n);
        pulse(3, !p[0]);
      join
      chk("edge flash", 0, (tmo + 1) * STEP, n);
      rd_chk(8'h04, 8'h04);
    end
    wr(8'h07, 8'h00);
    strobe_pin = 1'b0;
    wr(8'h04, 8'h1F);
    fork
      meas(n);
      pulse(20, 1'b1);
    join
    chk("level flash", 1, 20, n);
    rd_chk(8'h05, 8'h00);
    wr(8'h04, 8'h1F);
    fork
      meas(n);
      pulse(200, 1'b1);
    join
    chk("level timeout", 1, (tmo + 1) * STEP, n);
    rd_chk(8'h05, 8'h01);
    rd_chk(8'h05, 8'h00);
    // Torch entry, drop by pin, and restart only after a rewrite
    wr(8'h04, 8'h08);
    torch_request_pin = 1'b1;
    repeat (4) @(negedge clk_sys);
    outs(0, 1, 0, 1);
    torch_request_pin = 1'b0;
    repeat (4) @(negedge clk_sys);
    outs(0, 0, 0, 0);
    rd_chk(8'h04, 8'h00);
    torch_request_pin = 1'b1;
    repeat (4) @(negedge clk_sys);
    outs(0, 0, 0, 0);
    wr(8'h04, 8'h08);
    repeat (4) @(negedge clk_sys);
    outs(0, 1, 0, 1);
    wr(8'h04, 8'h00);
    outs(0, 0, 0, 0);
    wr(8'h04, 8'h08);
    fork
      meas(n);
      pulse(6, 1'b1);
      #40 torch_request_pin = 1'b0;
    join
    chk("torch to flash", 0, (tmo + 1) * STEP, n);
    wr(8'h04, 8'h08);
    torch_request_pin = 1'b1;
    repeat (4) @(negedge clk_sys);
    torch_request_pin = 1'b0;
    repeat (4) @(negedge clk_sys);
    pulse(6, 1'b1);
    repeat (4) @(negedge clk_sys);
    outs(0, 0, 0, 0);
    conclude();
  end
  // Watchdog well beyond the roughly ten thousand cycles needed
  initial begin
    repeat (60000) @(posedge clk_sys);
    num_errors++;
    conclude();
  end
endmodule // tb_top
`default_nettype wire
